/* File: core/abc_top.sv */
// address break comparator: apb registers, bus watch, flag and request
`timescale 1ns/100ps
module abc_top (
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // cpu internal bus watch
  input  wire abc_pkg::abc_cpu_bus_s cpu_bus,
  input  wire logic                  rte_done,
  input  wire logic                  instr_done,
  // to cpu interrupt logic
  output logic                       break_irq,
  output logic                       irq_hold
);

  // ************************************************************
  // state
  // ************************************************************
  abc_pkg::abc_control_s ctrl_q;
  logic                  flag_q;
  logic                  flag_d;
  logic                  irq_en_q;
  logic                  armed_q;
  logic [15:0]           baddr_q;
  logic [15:0]           bdata_q;
  logic                  pready_q;
  logic [31:0]           prdata_q;
  logic                  pslverr_q;
  logic                  irq_q;
  logic                  hold_q;

  // ************************************************************
  // apb decode
  // ************************************************************
  wire acc_done  = psel & penable & pready_q;
  wire wr_done   = acc_done & pwrite;
  wire rd_done   = acc_done & ~pwrite;
  wire sel_ctrl  = (paddr == abc_pkg::OFS_CONTROL);
  wire sel_stat  = (paddr == abc_pkg::OFS_STATUS);
  wire sel_ah    = (paddr == abc_pkg::OFS_ADDR_HIGH);
  wire sel_al    = (paddr == abc_pkg::OFS_ADDR_LOW);
  wire sel_dh    = (paddr == abc_pkg::OFS_DATA_HIGH);
  wire sel_dl    = (paddr == abc_pkg::OFS_DATA_LOW);
  wire mapped    = sel_ctrl | sel_stat | sel_ah | sel_al | sel_dh | sel_dl;
  wire [7:0] stat_rd = {flag_q, irq_en_q, abc_pkg::STATUS_RSVD};

  // address compare codes; the reserved 1xx codes are never decoded
  localparam logic [2:0] AMSK_U12 = 3'h1;
  localparam logic [2:0] AMSK_U8  = 3'h2;
  localparam logic [2:0] AMSK_U4  = 3'h3;

  // read mux, unmapped reads zero
  wire [7:0] rd_byte =
    sel_ctrl ? ctrl_q :
    sel_stat ? stat_rd :
    sel_ah   ? baddr_q[15:8] :
    sel_al   ? baddr_q[7:0] :
    sel_dh   ? bdata_q[15:8] :
    sel_dl   ? bdata_q[7:0] : 8'h00;

  // one wait state: answer on the second access-phase edge
  // the ~pready_q term drops ready after one cycle, so a master that
  // keeps psel and penable up for a back-to-back transfer is answered only every second cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      prdata_q  <= {24'h00_0000, rd_byte};
      pslverr_q <= psel & penable & ~pready_q & ~mapped;
    end
  end

  // ************************************************************
  // bus cycle qualification
  // ************************************************************
  wire cyc_hit =
    (ctrl_q.cycle_sel == abc_pkg::CYC_EXEC)  ? cpu_bus.exec :
    (ctrl_q.cycle_sel == abc_pkg::CYC_READ)  ? cpu_bus.rd :
    (ctrl_q.cycle_sel == abc_pkg::CYC_WRITE) ? cpu_bus.wr :
    (cpu_bus.rd | cpu_bus.wr);

  // address mask, reserved codes fall back to full compare
  wire [15:0] amask =
    (ctrl_q.address_mask_sel == AMSK_U12) ? abc_pkg::MASK_U12 :
    (ctrl_q.address_mask_sel == AMSK_U8)  ? abc_pkg::MASK_U8 :
    (ctrl_q.address_mask_sel == AMSK_U4)  ? abc_pkg::MASK_U4 :
    abc_pkg::MASK_ALL;
  wire addr_hit = ((cpu_bus.addr ^ baddr_q) & amask) == 16'h0000;

  // lane in use: byte and 8-bit io on upper, word odd on lower
  wire lane_up = cpu_bus.byte_acc | cpu_bus.io8 | ~cpu_bus.addr[0];
  wire lane_lo = ~cpu_bus.byte_acc & ~cpu_bus.io8 & cpu_bus.addr[0];
  wire up_eq   = cpu_bus.data[15:8] == bdata_q[15:8];
  wire lo_eq   = cpu_bus.data[7:0] == bdata_q[7:0];

  // data qualifier per compare mode
  // full-word mode checks both bytes with no lane test, so a byte access
  // only hits there if the other lane happens to carry the low break byte
  wire data_hit =
    (ctrl_q.data_lane_sel == abc_pkg::DCMP_NONE) ? 1'b1 :
    (ctrl_q.data_lane_sel == abc_pkg::DCMP_LOW)  ? (lane_lo & lo_eq) :
    (ctrl_q.data_lane_sel == abc_pkg::DCMP_HIGH) ? (lane_up & up_eq) :
    (up_eq & lo_eq);

  wire match = cyc_hit & addr_hit & data_hit;

  // ************************************************************
  // flag: set wins over clear
  // ************************************************************
  wire stat_wr  = wr_done & sel_stat;
  wire flag_clr = stat_wr & ~pwdata[abc_pkg::BIT_FLAG] & armed_q;
  wire irq_en_d = stat_wr ? pwdata[abc_pkg::BIT_IRQ_EN] : irq_en_q;

  // next flag value, sets regardless of any preempting interrupt
  // a match in the clearing cycle keeps the flag, so no break is lost
  // while software is acknowledging the previous one
  always_comb begin
    flag_d = flag_q;
    if (flag_clr) begin
      flag_d = 1'b0;
    end
    if (match) begin
      flag_d = 1'b1;
    end
  end

  // flag, enable and read-as-one tracker
  // the arm is dropped by any clear, so software must read the flag as one
  // again before the next write of zero can take effect
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_q   <= 1'b0;
      irq_en_q <= 1'b0;
      armed_q  <= 1'b0;
    end else begin
      flag_q   <= flag_d;
      irq_en_q <= irq_en_d;
      if (flag_clr) begin
        armed_q <= 1'b0;
      end else if (rd_done & sel_stat & flag_q) begin
        armed_q <= 1'b1;
      end
    end
  end

  // ************************************************************
  // configuration registers
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q  <= abc_pkg::CONTROL_RESET;
      baddr_q <= abc_pkg::ADDR_RESET;
    end else begin
      if (wr_done & sel_ctrl) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wr_done & sel_ah) begin
        baddr_q[15:8] <= pwdata[7:0];
      end
      if (wr_done & sel_al) begin
        baddr_q[7:0] <= pwdata[7:0];
      end
    end
  end

  // break data has no reset
  // software must load both bytes before enabling a data compare,
  // otherwise the compare runs against whatever power-up left here
  always_ff @(posedge clk_sys) begin
    if (wr_done & sel_dh) begin
      bdata_q[15:8] <= pwdata[7:0];
    end
    if (wr_done & sel_dl) begin
      bdata_q[7:0] <= pwdata[7:0];
    end
  end

  // ************************************************************
  // request and return hold-off
  // ************************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_q  <= 1'b0;
      hold_q <= 1'b0;
    end else begin
      irq_q <= flag_d & irq_en_d;
      if (ctrl_q.return_interrupt_enable) begin
        hold_q <= 1'b0;
      end else if (rte_done) begin
        hold_q <= 1'b1;
      end else if (instr_done) begin
        hold_q <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign pready    = pready_q;
  assign prdata    = prdata_q;
  assign pslverr   = pslverr_q;
  assign break_irq = irq_q;
  assign irq_hold  = hold_q;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  match_sets_flag_a: assert property (match |=> flag_q)
    else $error("match did not set flag");
  clear_needs_read_a: assert property ($fell(flag_q) |-> $past(armed_q))
    else $error("flag cleared without prior read");
  clear_works_a: assert property (flag_clr && !match |=> !flag_q)
    else $error("armed clear did not clear flag");
  irq_follows_a: assert property (##1 break_irq == (flag_q && irq_en_q))
    else $error("request not equal to flag and enable");
  rsvd_ones_a: assert property (rd_done && sel_stat
                                |-> prdata[5:0] == abc_pkg::STATUS_RSVD)
    else $error("reserved status bits not one");
  addr_reset_a: assert property ($past(rst) |-> baddr_q == abc_pkg::ADDR_RESET)
    else $error("break address not ffff after reset");
  hold_set_a: assert property (rte_done && !ctrl_q.return_interrupt_enable |=> irq_hold)
    else $error("return hold-off not raised");
  hold_end_a: assert property (irq_hold && instr_done && !rte_done |=> !irq_hold)
    else $error("hold-off outlived next instruction");
  no_hold_a: assert property (ctrl_q.return_interrupt_enable |=> !irq_hold)
    else $error("hold-off while return enable set");
  exec_sel_a: assert property (ctrl_q.cycle_sel == abc_pkg::CYC_EXEC && !cpu_bus.exec
                               |-> !match)
    else $error("match outside selected cycle");
  mask_u4_a: assert property (ctrl_q.address_mask_sel == 3'h3 && cyc_hit && data_hit
                 && cpu_bus.addr[15:12] == baddr_q[15:12] |-> match)
    else $error("upper 4-bit compare failed");
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");

  // cycle select gates every match
  read_sel_a: assert property (ctrl_q.cycle_sel == abc_pkg::CYC_READ && !cpu_bus.rd
                               |-> !match)
    else $error("match outside read cycle");
  write_sel_a: assert property (ctrl_q.cycle_sel == abc_pkg::CYC_WRITE && !cpu_bus.wr
                                |-> !match)
    else $error("match outside write cycle");
  rdwr_sel_a: assert property (ctrl_q.cycle_sel == abc_pkg::CYC_RDWR
                               && !cpu_bus.rd && !cpu_bus.wr |-> !match)
    else $error("match outside data cycle");

  // address masking per compare code
  mask_full_a: assert property (ctrl_q.address_mask_sel == 3'h0
                                && cpu_bus.addr != baddr_q |-> !match)
    else $error("full address compare failed");
  mask_u12_a: assert property (ctrl_q.address_mask_sel == AMSK_U12 && cyc_hit && data_hit
                               && cpu_bus.addr[15:4] == baddr_q[15:4] |-> match)
    else $error("upper 12-bit compare failed");
  mask_u8_a: assert property (ctrl_q.address_mask_sel == AMSK_U8 && cyc_hit && data_hit
                              && cpu_bus.addr[15:8] == baddr_q[15:8] |-> match)
    else $error("upper 8-bit compare failed");
  mask_miss_a: assert property (ctrl_q.address_mask_sel == AMSK_U4
                                && cpu_bus.addr[15:12] != baddr_q[15:12] |-> !match)
    else $error("upper 4-bit mismatch matched");

  // data lane qualifier per compare mode
  dnone_a: assert property (ctrl_q.data_lane_sel == abc_pkg::DCMP_NONE
                            && cyc_hit && addr_hit |-> match)
    else $error("no-data compare missed");
  dlow_lane_a: assert property (ctrl_q.data_lane_sel == abc_pkg::DCMP_LOW
                                && !lane_lo |-> !match)
    else $error("low compare on upper lane");
  dhigh_lane_a: assert property (ctrl_q.data_lane_sel == abc_pkg::DCMP_HIGH
                                 && !lane_up |-> !match)
    else $error("high compare on lower lane");
  dfull_a: assert property (ctrl_q.data_lane_sel == abc_pkg::DCMP_FULL
                            && cpu_bus.data != bdata_q |-> !match)
    else $error("full data mismatch matched");
  dlow_eq_a: assert property (ctrl_q.data_lane_sel == abc_pkg::DCMP_LOW
                              && cpu_bus.data[7:0] != bdata_q[7:0] |-> !match)
    else $error("low byte mismatch matched");

  // flag only moves on a match or an armed clear
  flag_keeps_a: assert property (flag_q && !flag_clr |=> flag_q)
    else $error("flag dropped without armed clear");
  only_match_a: assert property (!flag_q && !match |=> !flag_q)
    else $error("flag set without match");
  irq_off_a: assert property (!irq_en_q |-> !break_irq)
    else $error("request while disabled");

  // bus answer shape and reset state
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  reset_outs_a: assert property ($past(rst) |-> !break_irq && !irq_hold && !pready
                                 && !flag_q)
    else $error("outputs not idle after reset");

  cov_break: cover property (match ##1 break_irq);
  cov_clear: cover property (rd_done && sel_stat && flag_q ##[1:20] $fell(flag_q));
  cov_hold: cover property (rte_done && !ctrl_q.return_interrupt_enable ##[1:10] instr_done);
  cov_byte: cover property (match && cpu_bus.byte_acc &&
                            ctrl_q.data_lane_sel == abc_pkg::DCMP_HIGH);
  cov_mask: cover property (match && ctrl_q.address_mask_sel == AMSK_U4);

endmodule

/* File: core/abc_pkg.sv */
// address break comparator: shared constants and types
package abc_pkg;

  // ************************************************************
  // register byte offsets on the apb bus
  // ************************************************************
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_STATUS    = 8'h04;
  localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
  localparam logic [7:0] OFS_ADDR_LOW  = 8'h0c;
  localparam logic [7:0] OFS_DATA_HIGH = 8'h10;
  localparam logic [7:0] OFS_DATA_LOW  = 8'h14;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [7:0]  CONTROL_RESET  = 8'h80;
  localparam logic [15:0] ADDR_RESET     = 16'hffff;
  localparam logic [5:0]  STATUS_RSVD    = 6'h3f;
  localparam int          BIT_FLAG       = 7;
  localparam int          BIT_IRQ_EN     = 6;
  localparam int          BIT_RETURN_INTERRUPT_ENABLE     = 7;

  // ************************************************************
  // field encodings
  // ************************************************************
  typedef enum logic [1:0] {
    CYC_EXEC  = 2'h0,
    CYC_READ  = 2'h1,
    CYC_WRITE = 2'h2,
    CYC_RDWR  = 2'h3
  } abc_cycle_e;

  typedef enum logic [1:0] {
    DCMP_NONE = 2'h0,
    DCMP_LOW  = 2'h1,
    DCMP_HIGH = 2'h2,
    DCMP_FULL = 2'h3
  } abc_dcmp_e;

  localparam logic [15:0] MASK_ALL  = 16'hffff;
  localparam logic [15:0] MASK_U12  = 16'hfff0;
  localparam logic [15:0] MASK_U8   = 16'hff00;
  localparam logic [15:0] MASK_U4   = 16'hf000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic       return_interrupt_enable;
    abc_cycle_e cycle_sel;
    logic [2:0] address_mask_sel;
    abc_dcmp_e  data_lane_sel;
  } abc_control_s;

  typedef struct packed {
    logic        exec;      // instruction starts at addr (first byte)
    logic        rd;        // cpu data read cycle
    logic        wr;        // cpu data write cycle
    logic        byte_acc;  // byte-size access
    logic        io8;       // io register with 8-bit bus width
    logic [15:0] addr;
    logic [15:0] data;      // [15:8] upper lane, [7:0] lower lane
  } abc_cpu_bus_s;

endpackage

/* File: sim/abc_cpu_model.sv */
// cpu bus model: drives watched bus cycles and completion pulses
`timescale 1ns/100ps
module abc_cpu_model (
  // clock
  input  wire logic             clk_sys,
  // watched cpu bus and pulses
  output abc_pkg::abc_cpu_bus_s cpu_bus,
  output logic                  rte_done,
  output logic                  instr_done
);
  // ******
  // bus cycles
  // ******
  // idle bus at time zero
  initial begin
    cpu_bus = '0;
    rte_done = 1'b0;
    instr_done = 1'b0;
  end

  // one cycle of kind k (0 exec, 1 read, 2 write), then inverted idle
  task automatic cyc(input int k, input logic bsz, io8, input logic [15:0] a, d);
    abc_pkg::abc_cpu_bus_s b;
    b = '0;
    b.exec = (k == 0);
    b.rd = (k == 1);
    b.wr = (k == 2);
    b.byte_acc = bsz;
    b.io8 = io8;
    b.addr = a;
    if (bsz || io8) begin
      b.data = {d[15:8], ~d[15:8]};
    end else if (a[0]) begin
      b.data = {~d[7:0], d[7:0]};
    end else begin
      b.data = d;
    end
    @(posedge clk_sys);
    cpu_bus <= b;
    @(posedge clk_sys);
    cpu_bus <= {5'h00, ~b.addr, ~b.data}; // released bus never shows old value
  endtask

  // one-cycle return (r=1) or instruction-done (r=0) pulse
  task automatic pulse(input logic r);
    @(posedge clk_sys);
    rte_done <= r;
    instr_done <= ~r;
    @(posedge clk_sys);
    rte_done <= 1'b0;
    instr_done <= 1'b0;
  endtask
endmodule

/* File: sim/abc_top_tb.sv */
// testbench for the address break comparator
`timescale 1ns/100ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", n, e, g); end end
module abc_top_tb;
  // ******
  // signals
  // ******
  logic                  clk_sys = 1'b0;
  logic                  rst     = 1'b1;
  logic                  psel    = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite  = 1'b0;
  logic [7:0]            paddr   = 8'h00;
  logic [31:0]           pwdata  = 32'h0;
  logic                  pready;
  logic [31:0]           prdata;
  logic                  pslverr;
  abc_pkg::abc_cpu_bus_s cpu_bus;
  logic                  rte_done;
  logic                  instr_done;
  logic                  break_irq;
  logic                  irq_hold;
  logic [7:0]            q;
  logic                  e;
  int                    bad_count = 0;
  int                    cmp_count = 0;
  int                    cyc_n     = 0;

  abc_top i_abc_top (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cpu_bus(cpu_bus), .rte_done(rte_done), .instr_done(instr_done),
    .break_irq(break_irq), .irq_hold(irq_hold));
  abc_cpu_model i_abc_cpu_model (.clk_sys(clk_sys), .cpu_bus(cpu_bus),
    .rte_done(rte_done), .instr_done(instr_done));

  // 50 mhz clock and cycle ceiling
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      conclude();
    end
  end

  // ******
  // apb and helpers
  // ******
  task automatic apb(input logic w, input logic [7:0] a, d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask
  // address compare code top bit always 0
  task automatic ctl(input logic rt, input logic [1:0] c, am, dm);
    wr(abc_pkg::OFS_CONTROL, {rt, c, 1'b0, am, dm});
  endtask
  // flag seen on request and status, then cleared by read and write 0
  task automatic flag(input logic x);
    @(negedge clk_sys);
    `CHK("break_irq", x, break_irq)
    rd(abc_pkg::OFS_STATUS);
    `CHK("status", {x, 7'h7f}, q)
    wr(abc_pkg::OFS_STATUS, 8'h40);
    @(negedge clk_sys);
    `CHK("cleared", 1'b0, break_irq)
  endtask

  // ******
  // scenarios
  // ******
  task automatic t_reset;
    logic [7:0] v [4] = '{8'h12, 8'h34, 8'ha5, 8'h5a};
    rd(abc_pkg::OFS_CONTROL);
    `CHK("control", abc_pkg::CONTROL_RESET, q)
    rd(abc_pkg::OFS_STATUS);
    `CHK("status", 8'h3f, q)
    rd(abc_pkg::OFS_ADDR_HIGH);
    `CHK("addr_high", 8'hff, q)
    rd(abc_pkg::OFS_ADDR_LOW);
    `CHK("addr_low", 8'hff, q)
    rd(8'h18);
    `CHK("unmapped", 9'h100, {e, q})
    wr(abc_pkg::OFS_STATUS, 8'h40);
    rd(abc_pkg::OFS_STATUS);
    `CHK("enable", 8'h7f, q)
    for (int i = 0; i < 4; i++) wr(abc_pkg::OFS_ADDR_HIGH + 8'(4 * i), v[i]);
    for (int i = 0; i < 4; i++) begin
      rd(abc_pkg::OFS_ADDR_HIGH + 8'(4 * i));
      `CHK("readback", v[i], q)
    end
    $display("t_reset done");
  endtask

  task automatic t_cycle;
    for (int c = 0; c < 4; c++) begin
      ctl(1'b1, 2'(c), 2'h0, 2'h0);
      for (int k = 0; k < 3; k++) begin
        i_abc_cpu_model.cyc(k, 1'b0, 1'b0, 16'h1234, 16'h0);
        flag((c == k) || (c == 3 && k != 0));
      end
    end
    $display("t_cycle done");
  endtask

  task automatic t_mask;
    for (int m = 0; m < 4; m++) begin
      ctl(1'b1, 2'h1, 2'(m), 2'h0);
      for (int j = 0; j < 4; j++) begin
        i_abc_cpu_model.cyc(1, 1'b0, 1'b0, 16'h1234 ^ (16'h1 << (4 * j)), 16'h0);
        flag(j < m);
      end
    end
    $display("t_mask done");
  endtask

  // entry: mode, byte, io8 | odd, expected | bus data
  task automatic t_data;
    logic [23:0] t [9] = '{24'h240000, 24'haca500, 24'ha85a00, 24'h4c005a, 24'h40005a,
                           24'h9ca500, 24'h58005a, 24'hc4a55a, 24'hc0a55b};
    for (int i = 0; i < 9; i++) begin
      ctl(1'b1, 2'h3, 2'h1, t[i][23:22]);
      i_abc_cpu_model.cyc(1, t[i][21], t[i][20], {15'h091a, t[i][19]}, t[i][15:0]);
      flag(t[i][18]);
    end
    $display("t_data done");
  endtask

  task automatic t_clear;
    ctl(1'b1, 2'h2, 2'h0, 2'h0);
    i_abc_cpu_model.cyc(2, 1'b0, 1'b0, 16'h1234, 16'h0);
    wr(abc_pkg::OFS_STATUS, 8'h40);
    @(negedge clk_sys);
    `CHK("unread_clear", 1'b1, break_irq)
    wr(abc_pkg::OFS_STATUS, 8'h00);
    @(negedge clk_sys);
    `CHK("disabled", 1'b0, break_irq)
    rd(abc_pkg::OFS_STATUS);
    `CHK("status", 8'hbf, q)
    wr(abc_pkg::OFS_STATUS, 8'hc0);
    @(negedge clk_sys);
    `CHK("write_one", 1'b1, break_irq)
    wr(abc_pkg::OFS_STATUS, 8'h40);
    @(negedge clk_sys);
    `CHK("armed_clear", 1'b0, break_irq)
    $display("t_clear done");
  endtask

  task automatic t_hold;
    ctl(1'b0, 2'h1, 2'h0, 2'h0);
    i_abc_cpu_model.pulse(1'b1);
    @(negedge clk_sys);
    `CHK("hold_set", 1'b1, irq_hold)
    repeat (3) @(negedge clk_sys);
    `CHK("hold_kept", 1'b1, irq_hold)
    i_abc_cpu_model.pulse(1'b0);
    @(negedge clk_sys);
    `CHK("hold_end", 1'b0, irq_hold)
    ctl(1'b1, 2'h1, 2'h0, 2'h0);
    i_abc_cpu_model.pulse(1'b1);
    @(negedge clk_sys);
    `CHK("no_hold", 1'b0, irq_hold)
    $display("t_hold done");
  endtask

  // counts and verdict
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // reset then scenarios
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset;
    t_cycle;
    t_mask;
    t_data;
    t_clear;
    t_hold;
    conclude;
  end
endmodule
